/* pkg/idle_regs_pkg.sv */
/*
 Constants for the management register group of a single-pair 100 Mb/s line interface:
 byte addresses, field positions, reset values and the test-mode encodings.
 Assumes a 32-bit AXI4-Lite slave in front; registers are 16 bits in the low half.
*/
//
// Overview of operation
// - Role bit fourteen: one master, zero slave
// - Role bit reset value follows package strap
// - Type field reads zero for 100BASE-T1
// - Test mode field encodes five legal modes
// - Soft reset clears coding registers and core
// - Soft reset bit writable and self-clearing
// - Soft reset forces loopback bit to zero
// - Bit ten permits receive clock stopping
// - Transmit idle seen latches until read
// - Receive idle seen latches until read
// - Transmit idle live shown unlatched
// - Receive idle live shown unlatched
// - Transmit clock stoppable read-only indication
package idle_regs_pkg;
	// ************************************************************
	// Register offsets, indexes times four
	// ************************************************************
	localparam logic [15:0] IDX_ROLE = 16'h1834;
	localparam logic [15:0] IDX_TEST = 16'h1836;
	localparam logic [15:0] IDX_CTRL = 16'h3000;
	localparam logic [15:0] IDX_STAT = 16'h3001;
	localparam logic [17:0] ADDR_ROLE = {IDX_ROLE, 2'b00};
	localparam logic [17:0] ADDR_TEST = {IDX_TEST, 2'b00};
	localparam logic [17:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
	localparam logic [17:0] ADDR_STAT = {IDX_STAT, 2'b00};
	// Own registers for interrupt status and mask
	localparam logic [17:0] ADDR_IRQ_STAT = 18'h0_0100;
	localparam logic [17:0] ADDR_IRQ_MASK = 18'h0_0104;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int ROLE_MAN_BIT = 15;
	localparam int ROLE_SEL_BIT = 14;
	localparam int TEST_LSB = 13;
	localparam int CTRL_RST_BIT = 15;
	localparam int CTRL_LOOP_BIT = 14;
	localparam int CTRL_RXSTOP_BIT = 10;
	localparam int STAT_TXSEEN_BIT = 11;
	localparam int STAT_RXSEEN_BIT = 10;
	localparam int STAT_TXLIVE_BIT = 9;
	localparam int STAT_RXLIVE_BIT = 8;
	localparam int STAT_TXSTOP_BIT = 6;
	// ************************************************************
	// Reset values and codes
	// ************************************************************
	localparam logic [3:0] TYPE_100BT1 = 4'h0;
	localparam logic [15:0] TEST_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [1:0] AXI_OKAY = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		TM_NORMAL = 3'h0,
		TM_1 = 3'h1,
		TM_2 = 3'h2,
		TM_4 = 3'h4,
		TM_5 = 3'h5
	} test_mode_e;
endpackage

/* core/pma_pcs_control_status_regs.sv */
/*
 Management register group: role, test mode, coding-layer control and idle status,
 reached over AXI4-Lite, with a sticky interrupt for idle events.
 Assumes synchronous inputs and strap pins stable around reset release.
*/
`timescale 1ns/1ps
module pma_pcs_control_status_regs #(
	parameter int ADDR_W = 18
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// Straps and package select
	input wire logic pkg36_i,
	input wire logic led0_bootstrap_i,
	input wire logic rxdata3_bootstrap_i,
	// Coding-path idle indications
	input wire logic tx_idle_i,
	input wire logic rx_idle_i,
	input wire logic tx_clock_stoppable_i,
	// Line data for loopback
	input wire logic [3:0] tx_data_i,
	input wire logic [3:0] line_rx_data_i,
	// Control outputs
	output logic phy_role_select_o,
	output logic [2:0] test_mode_o,
	output logic core_reset_o,
	output logic coding_layer_loopback_o,
	output logic rx_clock_stop_allow_o,
	output logic [3:0] rx_data_o,
	output logic irq_o,
	// AXI4-Lite write address, data and response
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ************************************************************
	// Write channel capture
	// ************************************************************
	logic aw_held; // Address captured
	logic w_held; // Data captured
	logic [ADDR_W-1:0] aw_addr;
	logic [15:0] w_data;
	logic [1:0] w_strb;
	logic wr_fire; // Both halves present, response free
	logic rd_fire;
	logic strap_pending; // Strap sampling pending after reset
	logic soft_reset; // One-cycle soft reset of coding group
	logic role_sel;
	logic [2:0] test_mode;
	logic [12:0] test_rsvd;
	logic loopback;
	logic rx_stop;
	logic tx_seen;
	logic rx_seen;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic stat_read; // Idle status is being read

	// Merge byte lanes into a 16-bit register
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nv,
		input logic [1:0] strb);
		merge = {strb[1] ? nv[15:8] : old[15:8], strb[0] ? nv[7:0] : old[7:0]};
	endfunction

	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign stat_read = rd_fire && (s_axi_araddr == ADDR_W'(idle_regs_pkg::ADDR_STAT));

	// Hold address until paired with data, either order
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	// Hold data until paired with address
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata[15:0];
			w_strb <= s_axi_wstrb[1:0];
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= idle_regs_pkg::AXI_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			unique case (aw_addr)
				ADDR_W'(idle_regs_pkg::ADDR_ROLE), ADDR_W'(idle_regs_pkg::ADDR_TEST),
				ADDR_W'(idle_regs_pkg::ADDR_CTRL), ADDR_W'(idle_regs_pkg::ADDR_STAT),
				ADDR_W'(idle_regs_pkg::ADDR_IRQ_STAT),
				ADDR_W'(idle_regs_pkg::ADDR_IRQ_MASK): s_axi_bresp <= idle_regs_pkg::AXI_OKAY;
				default: s_axi_bresp <= idle_regs_pkg::AXI_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Decoded write strobes
	logic wr_role, wr_test, wr_ctrl, wr_istat, wr_imask;
	assign wr_role = wr_fire && (aw_addr == ADDR_W'(idle_regs_pkg::ADDR_ROLE));
	assign wr_test = wr_fire && (aw_addr == ADDR_W'(idle_regs_pkg::ADDR_TEST));
	assign wr_ctrl = wr_fire && (aw_addr == ADDR_W'(idle_regs_pkg::ADDR_CTRL));
	assign wr_istat = wr_fire && (aw_addr == ADDR_W'(idle_regs_pkg::ADDR_IRQ_STAT));
	assign wr_imask = wr_fire && (aw_addr == ADDR_W'(idle_regs_pkg::ADDR_IRQ_MASK));

	// ************************************************************
	// Role register
	// ************************************************************
	// Strap is sampled one clock after release, never under reset itself
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			strap_pending <= 1'b1;
			role_sel <= 1'b0;
		end else if (strap_pending) begin
			strap_pending <= 1'b0;
			role_sel <= pkg36_i ? led0_bootstrap_i : rxdata3_bootstrap_i;
		end else if (wr_role && w_strb[1]) begin
			role_sel <= w_data[idle_regs_pkg::ROLE_SEL_BIT];
		end
	end
	assign phy_role_select_o = role_sel;

	// ************************************************************
	// Test mode register
	// ************************************************************
	// Reserved codes are stored; the line logic treats them as normal
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			{test_mode, test_rsvd} <= idle_regs_pkg::TEST_RESET;
		end else if (wr_test) begin
			{test_mode, test_rsvd} <= merge({test_mode, test_rsvd}, w_data, w_strb);
		end
	end

	// Only legal codes reach the line
	always_comb begin
		unique case (test_mode)
			idle_regs_pkg::TM_1, idle_regs_pkg::TM_2, idle_regs_pkg::TM_4,
			idle_regs_pkg::TM_5: test_mode_o = test_mode;
			default: test_mode_o = idle_regs_pkg::TM_NORMAL;
		endcase
	end

	// ************************************************************
	// Coding-layer control
	// ************************************************************
	// Soft reset pulses one cycle then reads back as zero
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= wr_ctrl && w_strb[1] && w_data[idle_regs_pkg::CTRL_RST_BIT];
		end
	end
	assign core_reset_o = soft_reset;

	// Loopback and clock-stop permission; soft reset wins over writes
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			loopback <= idle_regs_pkg::CTRL_RESET[idle_regs_pkg::CTRL_LOOP_BIT];
			rx_stop <= idle_regs_pkg::CTRL_RESET[idle_regs_pkg::CTRL_RXSTOP_BIT];
		end else if (soft_reset) begin
			loopback <= 1'b0;
			rx_stop <= idle_regs_pkg::CTRL_RESET[idle_regs_pkg::CTRL_RXSTOP_BIT];
		end else if (wr_ctrl && w_strb[1]) begin
			loopback <= w_data[idle_regs_pkg::CTRL_LOOP_BIT];
			rx_stop <= w_data[idle_regs_pkg::CTRL_RXSTOP_BIT];
		end
	end
	assign coding_layer_loopback_o = loopback;
	assign rx_clock_stop_allow_o = rx_stop;

	// Receive data path: loopback returns transmit data
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rx_data_o <= '0;
		end else begin
			rx_data_o <= loopback ? tx_data_i : line_rx_data_i;
		end
	end

	// ************************************************************
	// Idle status latches
	// ************************************************************
	// Read clears, but a live condition at the read keeps the flag set
	always_ff @(posedge clock_i) begin
		if (!resetn_i || soft_reset) begin
			tx_seen <= 1'b0;
			rx_seen <= 1'b0;
		end else begin
			tx_seen <= tx_idle_i || (tx_seen && !stat_read);
			rx_seen <= rx_idle_i || (rx_seen && !stat_read);
		end
	end

	// ************************************************************
	// Interrupt status and mask
	// ************************************************************
	// Bit 0 transmit idle entry, bit 1 receive idle entry; set wins over clear
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= {rx_idle_i && !rx_seen, tx_idle_i && !tx_seen}
				| (irq_stat & ~((wr_istat && w_strb[0]) ? w_data[1:0] : 2'b00));
		end
	end

	// Mask: one keeps the bit off the interrupt line
	// Reset leaves every source unmasked, so software masks what it ignores
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			irq_mask <= '0;
		end else if (wr_imask && w_strb[0]) begin
			irq_mask <= w_data[1:0];
		end
	end
	assign irq_o = |(irq_stat & ~irq_mask);

	// ************************************************************
	// Read channel
	// ************************************************************
	// Read data registered, answered one cycle after the address is taken
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= idle_regs_pkg::AXI_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= idle_regs_pkg::AXI_OKAY;
			s_axi_rdata <= '0;
			unique case (s_axi_araddr)
				ADDR_W'(idle_regs_pkg::ADDR_ROLE): begin
					s_axi_rdata[idle_regs_pkg::ROLE_MAN_BIT] <= 1'b1;
					s_axi_rdata[idle_regs_pkg::ROLE_SEL_BIT] <= role_sel;
					s_axi_rdata[3:0] <= idle_regs_pkg::TYPE_100BT1;
				end
				ADDR_W'(idle_regs_pkg::ADDR_TEST): begin
					s_axi_rdata[15:0] <= {test_mode, test_rsvd};
				end
				ADDR_W'(idle_regs_pkg::ADDR_CTRL): begin
					s_axi_rdata[idle_regs_pkg::CTRL_LOOP_BIT] <= loopback;
					s_axi_rdata[idle_regs_pkg::CTRL_RXSTOP_BIT] <= rx_stop;
				end
				ADDR_W'(idle_regs_pkg::ADDR_STAT): begin
					s_axi_rdata[idle_regs_pkg::STAT_TXSEEN_BIT] <= tx_seen || tx_idle_i;
					s_axi_rdata[idle_regs_pkg::STAT_RXSEEN_BIT] <= rx_seen || rx_idle_i;
					s_axi_rdata[idle_regs_pkg::STAT_TXLIVE_BIT] <= tx_idle_i;
					s_axi_rdata[idle_regs_pkg::STAT_RXLIVE_BIT] <= rx_idle_i;
					s_axi_rdata[idle_regs_pkg::STAT_TXSTOP_BIT] <= tx_clock_stoppable_i;
				end
				ADDR_W'(idle_regs_pkg::ADDR_IRQ_STAT): s_axi_rdata[1:0] <= irq_stat;
				ADDR_W'(idle_regs_pkg::ADDR_IRQ_MASK): s_axi_rdata[1:0] <= irq_mask;
				default: s_axi_rresp <= idle_regs_pkg::AXI_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence ctrl_reset_write;
		wr_ctrl && w_strb[1] && w_data[idle_regs_pkg::CTRL_RST_BIT];
	endsequence
	a_reset_pulse_once: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ctrl_reset_write |=> core_reset_o ##1 !core_reset_o)
		else $error("soft reset not a single pulse");
	a_reset_self_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
		core_reset_o |-> $past(wr_ctrl && w_strb[1] && w_data[idle_regs_pkg::CTRL_RST_BIT]))
		else $error("soft reset held without write");
	a_loop_cleared: assert property (@(posedge clock_i) disable iff (!resetn_i)
		core_reset_o |=> !coding_layer_loopback_o)
		else $error("loopback survived soft reset");
	a_rxstop_follows: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(wr_ctrl && w_strb[1] && !soft_reset) |=>
		rx_clock_stop_allow_o == $past(w_data[idle_regs_pkg::CTRL_RXSTOP_BIT]))
		else $error("clock stop permission not written");
	a_tx_seen_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(tx_seen && !stat_read && !soft_reset) |=> tx_seen)
		else $error("transmit idle flag lost before read");
	a_rx_seen_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(rx_idle_i && !soft_reset) |=> rx_seen)
		else $error("receive idle flag not latched");
	a_seen_clear_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(stat_read && !tx_idle_i) |=> !tx_seen)
		else $error("transmit idle flag not cleared by read");
	a_live_bits: assert property (@(posedge clock_i) disable iff (!resetn_i)
		stat_read |=> s_axi_rdata[idle_regs_pkg::STAT_TXLIVE_BIT] == $past(tx_idle_i)
		&& s_axi_rdata[idle_regs_pkg::STAT_RXLIVE_BIT] == $past(rx_idle_i))
		else $error("live idle bits wrong");
	a_role_strap: assert property (@(posedge clock_i) disable iff (!resetn_i)
		strap_pending |=> phy_role_select_o ==
		($past(pkg36_i) ? $past(led0_bootstrap_i) : $past(rxdata3_bootstrap_i)))
		else $error("role not taken from strap");
	a_loop_data: assert property (@(posedge clock_i) disable iff (!resetn_i)
		coding_layer_loopback_o |=> rx_data_o == $past(tx_data_i))
		else $error("loopback data not returned");

	// ************************************************************
	// Assertions on field writes, read-back and interrupt
	// ************************************************************
	// Software owns the role bit once the strap has been taken
	a_role_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(wr_role && w_strb[1] && !strap_pending) |=>
		phy_role_select_o == $past(w_data[idle_regs_pkg::ROLE_SEL_BIT]))
		else $error("role bit not written");
	// Mode field is stored as written, reserved codes included
	a_test_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(wr_test && w_strb[1]) |=>
		test_mode == $past(w_data[idle_regs_pkg::TEST_LSB +: $bits(test_mode)]))
		else $error("test mode field not written");
	// Type field never shows a reserved encoding
	a_type_reads_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(rd_fire && s_axi_araddr == ADDR_W'(idle_regs_pkg::ADDR_ROLE)) |=>
		s_axi_rdata[3:0] == idle_regs_pkg::TYPE_100BT1)
		else $error("type field not 100BASE-T1");
	// Clock-stop indication passes straight from the pin
	a_stop_bit_live: assert property (@(posedge clock_i) disable iff (!resetn_i)
		stat_read |=> s_axi_rdata[idle_regs_pkg::STAT_TXSTOP_BIT] ==
		$past(tx_clock_stoppable_i))
		else $error("transmit clock stop bit wrong");
	// Receive flag survives until a read or a soft reset
	a_rx_seen_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(rx_seen && !stat_read && !soft_reset) |=> rx_seen)
		else $error("receive idle flag lost before read");
	// A read with the condition gone empties the receive flag
	a_rx_clear_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(stat_read && !rx_idle_i) |=> !rx_seen)
		else $error("receive idle flag not cleared by read");
	// Loopback follows the written bit unless a soft reset overrides it
	a_loop_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(wr_ctrl && w_strb[1] && !soft_reset) |=>
		coding_layer_loopback_o == $past(w_data[idle_regs_pkg::CTRL_LOOP_BIT]))
		else $error("loopback bit not written");
	// Idle entry sets its event bit even against a same-cycle clear
	a_irq_tx_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(tx_idle_i && !tx_seen) |=> irq_stat[0])
		else $error("transmit idle event lost");
	// Same for the receive side
	a_irq_rx_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(rx_idle_i && !rx_seen) |=> irq_stat[1])
		else $error("receive idle event lost");
endmodule

/* tb/axi_lite_master.sv */
/*
 AXI4-Lite master model standing for the management controller.
 Assumes one clock from the bench; the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module axi_lite_master (
	// Clock
	input wire logic clock_i,
	// Write channels
	output logic [17:0] awaddr_o,
	output logic awvalid_o,
	input wire logic awready_i,
	output logic [31:0] wdata_o,
	output logic wvalid_o,
	input wire logic wready_i,
	input wire logic bvalid_i,
	output logic bready_o,
	// Read channels
	output logic [17:0] araddr_o,
	output logic arvalid_o,
	input wire logic arready_i,
	input wire logic rvalid_i,
	output logic rready_o
);
	// ************************************************************
	// Idle state and transfer tasks
	// ************************************************************
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
	end
	// Write: both channels offered together, each dropped once taken
	task automatic wr(input logic [17:0] a, input logic [31:0] d);
		@(posedge clock_i);
		awaddr_o <= a;
		wdata_o <= d;
		{awvalid_o, wvalid_o, bready_o} <= 3'b111;
		forever begin
			@(posedge clock_i);
			// Released payload is scrambled so stale values are never trusted
			if (awvalid_o && awready_i) begin
				awvalid_o <= 1'b0;
				awaddr_o <= ~a;
			end
			if (wvalid_o && wready_i) begin
				wvalid_o <= 1'b0;
				wdata_o <= ~d;
			end
			if (bvalid_i) begin
				bready_o <= 1'b0;
				break;
			end
		end
	endtask
	// Read: address held until taken, rready held until data seen
	task automatic rd(input logic [17:0] a);
		@(posedge clock_i);
		araddr_o <= a;
		{arvalid_o, rready_o} <= 2'b11;
		forever begin
			@(posedge clock_i);
			if (arvalid_o && arready_i) begin
				arvalid_o <= 1'b0;
				araddr_o <= ~a;
			end
			if (rvalid_i) begin
				rready_o <= 1'b0;
				break;
			end
		end
	endtask
endmodule

/* tb/tb.sv */
/*
 Self-checking bench for the management register group.
 Assumes the master model drives the bus; a monitor checks every response.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb;
	// Bench signals, named as the design ports except idle_v, which drives tx_idle_i and rx_idle_i
	logic clock_i, resetn_i, pkg36_i, led0_bootstrap_i, rxdata3_bootstrap_i;
	logic [1:0] idle_v;
	logic tx_clock_stoppable_i;
	logic [3:0] tx_data_i, line_rx_data_i, rx_data_o;
	logic phy_role_select_o, core_reset_o, coding_layer_loopback_o;
	logic rx_clock_stop_allow_o, irq_o;
	logic [2:0] test_mode_o;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	// Expected responses, oldest first
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [33:0] re;
	logic [3:0] lb_exp;
	logic lb_vld;
	int checks, n_mismatch, n_crst;
	// ************************************************************
	// Clock, instances and monitors
	// ************************************************************
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	pma_pcs_control_status_regs pma_pcs_control_status_regs_inst (.clock_i(clock_i),
		.resetn_i(resetn_i), .pkg36_i(pkg36_i), .led0_bootstrap_i(led0_bootstrap_i),
		.rxdata3_bootstrap_i(rxdata3_bootstrap_i), .tx_idle_i(idle_v[0]), .rx_idle_i(idle_v[1]),
		.tx_clock_stoppable_i(tx_clock_stoppable_i), .tx_data_i(tx_data_i),
		.line_rx_data_i(line_rx_data_i), .phy_role_select_o(phy_role_select_o),
		.test_mode_o(test_mode_o), .core_reset_o(core_reset_o),
		.coding_layer_loopback_o(coding_layer_loopback_o),
		.rx_clock_stop_allow_o(rx_clock_stop_allow_o), .rx_data_o(rx_data_o), .irq_o(irq_o),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	axi_lite_master axi_lite_master_inst (.clock_i(clock_i), .awaddr_o(s_axi_awaddr),
		.awvalid_o(s_axi_awvalid), .awready_i(s_axi_awready), .wdata_o(s_axi_wdata),
		.wvalid_o(s_axi_wvalid), .wready_i(s_axi_wready), .bvalid_i(s_axi_bvalid),
		.bready_o(s_axi_bready), .araddr_o(s_axi_araddr), .arvalid_o(s_axi_arvalid),
		.arready_i(s_axi_arready), .rvalid_i(s_axi_rvalid), .rready_o(s_axi_rready));
	// Response monitor takes the oldest note at each handshake
	always @(posedge clock_i) begin
		if (s_axi_rvalid && s_axi_rready) begin
			re = rq.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, re)
		end
		if (s_axi_bvalid && s_axi_bready) begin
			re = {bq.pop_front(), 32'h0000_0000};
			`CHK(s_axi_bresp, re[33:32])
		end
	end
	// Random data each cycle; receive data follows the loopback choice a cycle late
	always @(posedge clock_i) begin
		tx_data_i <= 4'($urandom);
		line_rx_data_i <= 4'($urandom);
		if (core_reset_o) n_crst++;
		if (!resetn_i) lb_vld <= 1'b0;
		else begin
			if (lb_vld) `CHK(rx_data_o, lb_exp)
			lb_vld <= 1'b1;
			lb_exp <= coding_layer_loopback_o ? tx_data_i : line_rx_data_i;
		end
	end
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic rd(input logic [17:0] a, input logic [31:0] e,
		input logic [1:0] r = idle_regs_pkg::AXI_OKAY);
		rq.push_back({r, e});
		axi_lite_master_inst.rd(a);
	endtask
	task automatic wr(input logic [17:0] a, input logic [31:0] d,
		input logic [1:0] r = idle_regs_pkg::AXI_OKAY);
		bq.push_back(r);
		axi_lite_master_inst.wr(a, d);
	endtask
	// Reset with given straps, held for twenty cycles
	task automatic rst(input logic p, input logic l, input logic x);
		pkg36_i <= p;
		led0_bootstrap_i <= l;
		rxdata3_bootstrap_i <= x;
		resetn_i <= 1'b0;
		repeat (20) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
	endtask
	// Idle flag: latched then cleared by read; held live then re-set on read
	task automatic idle(input int k, input logic [31:0] seen, input logic [31:0] live);
		idle_v[k] <= 1'b1;
		repeat (3) @(posedge clock_i);
		idle_v[k] <= 1'b0;
		rd(idle_regs_pkg::ADDR_STAT, seen);
		rd(idle_regs_pkg::ADDR_STAT, 32'h0000_0000);
		idle_v[k] <= 1'b1;
		tx_clock_stoppable_i <= 1'b1;
		repeat (2) rd(idle_regs_pkg::ADDR_STAT, seen | live | 32'h0000_0040);
		idle_v[k] <= 1'b0;
		tx_clock_stoppable_i <= 1'b0;
		rd(idle_regs_pkg::ADDR_STAT, seen);
	endtask
	task automatic finish_test();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial begin
		void'($urandom(2008));
		{resetn_i, idle_v, tx_clock_stoppable_i, tx_data_i, line_rx_data_i} = '0;
		{checks, n_mismatch, n_crst, lb_vld} = '0;
		s_axi_wstrb = 4'hF;
		rst(1'b1, 1'b1, 1'b0);
		rd(idle_regs_pkg::ADDR_ROLE, 32'h0000_C000);
		`CHK(phy_role_select_o, 1'b1)
		wr(idle_regs_pkg::ADDR_ROLE, 32'h0000_0000);
		rd(idle_regs_pkg::ADDR_ROLE, 32'h0000_8000);
		`CHK(phy_role_select_o, 1'b0)
		for (int i = 0; i < 8; i++) begin
			wr(idle_regs_pkg::ADDR_TEST, 32'(i) << 13);
			@(posedge clock_i);
			`CHK(test_mode_o, (i == 3 || i > 5) ? 3'h0 : 3'(i))
			rd(idle_regs_pkg::ADDR_TEST, 32'(i) << 13);
		end
		// Byte lanes: each strobe writes its own half only
		s_axi_wstrb <= 4'h1;
		wr(idle_regs_pkg::ADDR_TEST, 32'h0000_A0FF);
		rd(idle_regs_pkg::ADDR_TEST, 32'h0000_E0FF);
		s_axi_wstrb <= 4'h2;
		wr(idle_regs_pkg::ADDR_TEST, 32'h0000_A000);
		s_axi_wstrb <= 4'hF;
		rd(idle_regs_pkg::ADDR_TEST, 32'h0000_A0FF);
		`CHK(test_mode_o, idle_regs_pkg::TM_5)
		wr(idle_regs_pkg::ADDR_CTRL, 32'h0000_4400);
		rd(idle_regs_pkg::ADDR_CTRL, 32'h0000_4400);
		`CHK({coding_layer_loopback_o, rx_clock_stop_allow_o}, 2'b11)
		idle(0, 32'h0000_0800, 32'h0000_0200);
		idle(1, 32'h0000_0400, 32'h0000_0100);
		// Soft reset with a latched flag pending and loopback set
		idle_v[0] <= 1'b1;
		@(posedge clock_i);
		idle_v[0] <= 1'b0;
		wr(idle_regs_pkg::ADDR_CTRL, 32'h0000_C400);
		repeat (2) @(posedge clock_i);
		`CHK(n_crst, 1)
		`CHK({coding_layer_loopback_o, rx_clock_stop_allow_o}, 2'b00)
		rd(idle_regs_pkg::ADDR_CTRL, 32'h0000_0000);
		rd(idle_regs_pkg::ADDR_STAT, 32'h0000_0000);
		// Interrupt masked, unmasked, then cleared
		wr(idle_regs_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
		wr(idle_regs_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
		rd(idle_regs_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
		idle_v[0] <= 1'b1;
		@(posedge clock_i);
		idle_v[0] <= 1'b0;
		rd(idle_regs_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
		`CHK(irq_o, 1'b0)
		wr(idle_regs_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
		@(posedge clock_i);
		`CHK(irq_o, 1'b1)
		wr(idle_regs_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
		@(posedge clock_i);
		`CHK(irq_o, 1'b0)
		rd(idle_regs_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
		// Unmapped place answers with an error and zero data
		rd(18'h0_0200, 32'h0000_0000, idle_regs_pkg::AXI_SLVERR);
		wr(18'h0_0200, 32'h0000_FFFF, idle_regs_pkg::AXI_SLVERR);
		// Strap sources per package
		rst(1'b0, 1'b1, 1'b0);
		rd(idle_regs_pkg::ADDR_ROLE, 32'h0000_8000);
		rst(1'b0, 1'b0, 1'b1);
		rd(idle_regs_pkg::ADDR_ROLE, 32'h0000_C000);
		rst(1'b1, 1'b0, 1'b1);
		rd(idle_regs_pkg::ADDR_ROLE, 32'h0000_8000);
		repeat (3) @(posedge clock_i);
		finish_test();
	end
	// Whole run needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge clock_i);
		n_mismatch++;
		finish_test();
	end
endmodule
